// ===== rtl/base_t1_an_pkg.sv
// Constants for the autonegotiation ability register slice
package base_t1_an_pkg;

  // Management frame addressing
  localparam logic [4:0]  AN_DEVAD          = 5'h07;
  localparam logic [1:0]  FRAME_START       = 2'h0;
  localparam logic [1:0]  OP_ADDRESS        = 2'h0;
  localparam logic [1:0]  OP_WRITE          = 2'h1;
  localparam logic [1:0]  OP_READ_INC       = 2'h2;
  localparam logic [1:0]  OP_READ           = 2'h3;

  // Frame bit counts after the preamble
  localparam logic [5:0]  HEAD_BITS         = 6'h0D;
  localparam logic [5:0]  DATA_BITS         = 6'h10;
  localparam logic [5:0]  WRITE_BITS        = 6'h12;
  localparam logic [5:0]  COUNT_MAX         = 6'h3F;
  localparam int          PREAMBLE_ONES     = 32;

  // Register addresses in the autonegotiation device
  localparam logic [15:0] REG_ADV_MIDDLE    = 16'h0203;
  localparam logic [15:0] REG_ADV_UPPER     = 16'h0204;
  localparam logic [15:0] REG_LP_LOW        = 16'h0205;
  localparam logic [15:0] REG_LP_MIDDLE     = 16'h0206;
  localparam logic [15:0] REG_LP_UPPER      = 16'h0207;

  // Reset values
  localparam logic [15:0] ADV_MIDDLE_RESET  = 16'h4000;
  localparam logic [15:0] ADV_UPPER_RESET   = 16'h0000;
  localparam logic [15:0] LP_LOW_RESET      = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

  // Field positions
  localparam int          LONG_REACH_BIT    = 14;
  localparam int          ROLE_BIT          = 4;
  localparam int          HI_ABLE_BIT       = 13;
  localparam int          HI_REQ_BIT        = 12;
  localparam int          LP_NEXT_PAGE_BIT  = 15;
  localparam int          LP_ACK_BIT        = 14;
  localparam int          LP_FAULT_BIT      = 13;
  localparam int          LP_FORCE_BIT      = 12;

  // Writable bits and bits that read back from the partner low word
  localparam logic [15:0] ADV_MIDDLE_RW     = 16'h4010;
  localparam logic [15:0] ADV_UPPER_RW      = 16'h3000;
  localparam logic [15:0] LP_LOW_VISIBLE    = 16'hFC1F;

endpackage : base_t1_an_pkg

// ===== rtl/tx_level_resolver.sv
// Transmit level resolution from local and partner advertisement
`timescale 1ns/1ns
`default_nettype none

module tx_level_resolver (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic local_hi_able,
  input  wire logic local_hi_req,
  input  wire logic partner_hi_able,
  input  wire logic partner_hi_req,
  output logic      tx_level_high
);

  logic next_tx_level_high;

  // Both must be able, then one request is enough; else low level
  always_comb begin
    next_tx_level_high = local_hi_able & partner_hi_able &
                         (local_hi_req | partner_hi_req);
  end

  // Low level is the safe state out of reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_level_high <= 1'b0;
    end else begin
      tx_level_high <= next_tx_level_high;
    end
  end

endmodule // tx_level_resolver

`default_nettype wire

// ===== rtl/base_t1_autoneg_ability_regs.sv
// Autonegotiation ability registers behind a clause 45 management slave
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Middle advert word at 0x0203, reset 0x4000
// - Bit 14 long-reach ability, writable, resets 1
// - Bit 4 role, writable, reset from strap
// - Role goes out as nonce bit 4
// - Upper advert word at 0x0204, bits 13:12 writable, rest read-only
// - Bit 13 high-level ability, reset from strap
// - Bit 12 high-level request, reset from strap
// - Either not able: both use low level
// - Both able, one requests: high level
// - Partner low word read-only at 0x0205
// - Low word read latches partner upper words
// - Bit 15 shows partner next page
// - Bit 14 shows partner acknowledge
// - Bit 13 shows partner remote fault
// - Bit 12 shows partner forced role
// - Bits 11:10 pause, 9:5 read zero
// - Force bit: 0 preference, 1 forced
// - Bits 4:0 partner selector field
module base_t1_autoneg_ability_regs #(
  parameter int PREAMBLE_MIN = base_t1_an_pkg::PREAMBLE_ONES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  phy_addr,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n,
  input  wire logic        strap_role_master,
  input  wire logic        strap_hi_able,
  input  wire logic        strap_hi_req,
  input  wire logic        force_role_bit,
  input  wire logic [15:0] partner_low_live,
  input  wire logic [15:0] partner_middle_live,
  input  wire logic [15:0] partner_upper_live,
  output logic             adv_long_reach,
  output logic             tx_nonce_role,
  output logic             tx_role_forced,
  output logic             adv_hi_able,
  output logic             adv_hi_req,
  output logic             tx_level_high
);

  ////////////////////////////////////////////////////////////////////////////
  // Types, checks and helpers

  typedef enum logic [4:0] {
    ST_PREAMBLE = 5'h01,
    ST_HEADER   = 5'h02,
    ST_TURN     = 5'h04,
    ST_WDATA    = 5'h08,
    ST_RDATA    = 5'h10
  } mdio_state_t;

  // The preamble counter is six bits wide and saturates
  if (PREAMBLE_MIN < 1 || PREAMBLE_MIN > 63) begin : g_bad_preamble
    $error("PREAMBLE_MIN must lie in 1..63");
  end

  localparam logic [5:0] PRE_MIN = 6'(PREAMBLE_MIN);

  // Reserved bits of the partner low word read as zero
  function automatic logic [15:0] lp_low_view(input logic [15:0] live);
    lp_low_view = live & base_t1_an_pkg::LP_LOW_VISIBLE;
  endfunction

  // Merge a host write into a word through its writable mask
  function automatic logic [15:0] masked_write(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [15:0] mask);
    masked_write = (data & mask) | (old & ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  mdio_state_t state;
  mdio_state_t next_state;
  logic [5:0]  bit_cnt;
  logic [5:0]  next_bit_cnt;
  logic [17:0] shift;
  logic [17:0] next_shift;
  logic [1:0]  op_code;
  logic [1:0]  next_op_code;
  logic [15:0] reg_addr;
  logic [15:0] next_reg_addr;
  logic [15:0] rd_shift;
  logic [15:0] next_rd_shift;
  logic        mdc_q;
  logic        next_mdio_out;
  logic        next_mdio_oe_n;
  logic [15:0] local_adv_middle_word;
  logic [15:0] next_local_adv_middle_word;
  logic [15:0] local_adv_upper_word;
  logic [15:0] next_local_adv_upper_word;
  logic [15:0] partner_base_page_middle_word;
  logic [15:0] next_partner_base_page_middle_word;
  logic [15:0] partner_base_page_upper_word;
  logic [15:0] next_partner_base_page_upper_word;
  logic        next_tx_role_forced;

  logic        mdc_rise;
  logic [12:0] header;
  logic        frame_ok;
  logic [15:0] wr_data;
  logic [15:0] rd_word;

  // The clock pin is sampled like data; a rising edge marks each bit
  assign mdc_rise = mdc & ~mdc_q;
  assign header   = {shift[11:0], mdio_in};
  assign wr_data  = {shift[14:0], mdio_in};

  // Only frames for this port and the autonegotiation device answer
  assign frame_ok = (header[12] == base_t1_an_pkg::FRAME_START[0]) &&
                    (header[9:5] == phy_addr) &&
                    (header[4:0] == base_t1_an_pkg::AN_DEVAD);

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Partner upper words come from the holding copies, not the live bus
  always_comb begin
    unique case (reg_addr)
      base_t1_an_pkg::REG_ADV_MIDDLE: rd_word = local_adv_middle_word;
      base_t1_an_pkg::REG_ADV_UPPER:  rd_word = local_adv_upper_word;
      base_t1_an_pkg::REG_LP_LOW:
        rd_word = lp_low_view(partner_low_live);
      base_t1_an_pkg::REG_LP_MIDDLE:
        rd_word = partner_base_page_middle_word;
      base_t1_an_pkg::REG_LP_UPPER:
        rd_word = partner_base_page_upper_word;
      default: rd_word = base_t1_an_pkg::UNMAPPED_READ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine and register updates

  always_comb begin
    next_state                         = state;
    next_bit_cnt                       = bit_cnt;
    next_shift                         = shift;
    next_op_code                       = op_code;
    next_reg_addr                      = reg_addr;
    next_rd_shift                      = rd_shift;
    next_mdio_out                      = mdio_out;
    next_mdio_oe_n                     = mdio_oe_n;
    next_local_adv_middle_word         = local_adv_middle_word;
    next_local_adv_upper_word          = local_adv_upper_word;
    next_partner_base_page_middle_word = partner_base_page_middle_word;
    next_partner_base_page_upper_word  = partner_base_page_upper_word;
    next_tx_role_forced                = force_role_bit;
    if (mdc_rise) begin
      unique case (state)
        // Count ones; a zero after enough of them opens a frame
        ST_PREAMBLE: begin
          if (mdio_in) begin
            if (bit_cnt != base_t1_an_pkg::COUNT_MAX) begin
              next_bit_cnt = bit_cnt + 6'h01;
            end
          end else if (bit_cnt >= PRE_MIN) begin
            next_state   = ST_HEADER;
            next_bit_cnt = 6'h00;
            next_shift   = 18'h00000;
          end else begin
            next_bit_cnt = 6'h00;
          end
        end
        // Second start bit, opcode, port and device address
        ST_HEADER: begin
          next_shift   = {shift[16:0], mdio_in};
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == base_t1_an_pkg::HEAD_BITS - 6'h01) begin
            next_bit_cnt = 6'h00;
            next_op_code = header[11:10];
            if (!frame_ok) begin
              // Foreign frame: its zeros break the preamble count
              next_state = ST_PREAMBLE;
            end else if (header[11]) begin
              next_state    = ST_TURN;
              next_rd_shift = rd_word;
              if (reg_addr == base_t1_an_pkg::REG_LP_LOW) begin
                next_partner_base_page_middle_word =
                  partner_middle_live;
                next_partner_base_page_upper_word  =
                  partner_upper_live;
              end
              if (header[11:10] == base_t1_an_pkg::OP_READ_INC) begin
                next_reg_addr = reg_addr + 16'h0001;
              end
            end else begin
              next_state = ST_WDATA;
            end
          end
        end
        // Host has released the line; drive the low turnaround bit
        ST_TURN: begin
          next_mdio_out  = 1'b0;
          next_mdio_oe_n = 1'b0;
          next_state     = ST_RDATA;
        end
        // Shift the word out most significant bit first
        ST_RDATA: begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == base_t1_an_pkg::DATA_BITS) begin
            next_mdio_oe_n = 1'b1;
            next_mdio_out  = 1'b0;
            next_bit_cnt   = 6'h00;
            next_state     = ST_PREAMBLE;
          end else begin
            next_mdio_out = rd_shift[15];
            next_rd_shift = {rd_shift[14:0], 1'b0};
          end
        end
        // Turnaround plus sixteen data bits from the host
        ST_WDATA: begin
          next_shift   = {shift[16:0], mdio_in};
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == base_t1_an_pkg::WRITE_BITS - 6'h01) begin
            next_bit_cnt = 6'h00;
            next_state   = ST_PREAMBLE;
            if (op_code == base_t1_an_pkg::OP_ADDRESS) begin
              next_reg_addr = wr_data;
            end else if (op_code == base_t1_an_pkg::OP_WRITE) begin
              if (reg_addr == base_t1_an_pkg::REG_ADV_MIDDLE) begin
                next_local_adv_middle_word = masked_write(
                  local_adv_middle_word, wr_data,
                  base_t1_an_pkg::ADV_MIDDLE_RW);
              end
              if (reg_addr == base_t1_an_pkg::REG_ADV_UPPER) begin
                next_local_adv_upper_word = masked_write(
                  local_adv_upper_word, wr_data,
                  base_t1_an_pkg::ADV_UPPER_RW);
              end
            end
          end
        end
        default: begin
          next_state     = ST_PREAMBLE;
          next_bit_cnt   = 6'h00;
          next_mdio_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Straps are caught while reset is held, so software sees them at once
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state                 <= ST_PREAMBLE;
      bit_cnt               <= 6'h00;
      shift                 <= 18'h00000;
      op_code               <= base_t1_an_pkg::OP_ADDRESS;
      reg_addr              <= 16'h0000;
      rd_shift              <= 16'h0000;
      mdc_q                 <= mdc; // No false rise at release
      mdio_out              <= 1'b0;
      mdio_oe_n             <= 1'b1;
      local_adv_middle_word <= base_t1_an_pkg::ADV_MIDDLE_RESET |
        (16'(strap_role_master) << base_t1_an_pkg::ROLE_BIT);
      local_adv_upper_word  <= base_t1_an_pkg::ADV_UPPER_RESET |
        (16'(strap_hi_able) << base_t1_an_pkg::HI_ABLE_BIT) |
        (16'(strap_hi_req) << base_t1_an_pkg::HI_REQ_BIT);
      partner_base_page_middle_word <= base_t1_an_pkg::LP_LOW_RESET;
      partner_base_page_upper_word  <= base_t1_an_pkg::LP_LOW_RESET;
      tx_role_forced        <= 1'b0;
    end else begin
      state                 <= next_state;
      bit_cnt               <= next_bit_cnt;
      shift                 <= next_shift;
      op_code               <= next_op_code;
      reg_addr              <= next_reg_addr;
      rd_shift              <= next_rd_shift;
      mdc_q                 <= mdc;
      mdio_out              <= next_mdio_out;
      mdio_oe_n             <= next_mdio_oe_n;
      local_adv_middle_word <= next_local_adv_middle_word;
      local_adv_upper_word  <= next_local_adv_upper_word;
      partner_base_page_middle_word <= next_partner_base_page_middle_word;
      partner_base_page_upper_word  <= next_partner_base_page_upper_word;
      tx_role_forced        <= next_tx_role_forced;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement fields toward the base page transmitter

  // Straight from the register flops, so the outputs never glitch
  assign adv_long_reach = local_adv_middle_word[base_t1_an_pkg::LONG_REACH_BIT];
  assign tx_nonce_role  = local_adv_middle_word[base_t1_an_pkg::ROLE_BIT];
  assign adv_hi_able    = local_adv_upper_word[base_t1_an_pkg::HI_ABLE_BIT];
  assign adv_hi_req     = local_adv_upper_word[base_t1_an_pkg::HI_REQ_BIT];

  // Resolution uses the live partner word so it tracks each new page
  tx_level_resolver u_level (
    .sys_clk         (sys_clk),
    .rstn            (rstn),
    .local_hi_able   (adv_hi_able),
    .local_hi_req    (adv_hi_req),
    .partner_hi_able (partner_upper_live[base_t1_an_pkg::HI_ABLE_BIT]),
    .partner_hi_req  (partner_upper_live[base_t1_an_pkg::HI_REQ_BIT]),
    .tx_level_high   (tx_level_high)
  );

endmodule // base_t1_autoneg_ability_regs

`default_nettype wire

// ===== verif/ability_regs_props.sv
// Concurrent checks on the ports of the ability register slice
`timescale 1ns/1ns
`default_nettype none

module ability_regs_props (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        mdc,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic        strap_role_master,
  input wire logic        strap_hi_able,
  input wire logic        strap_hi_req,
  input wire logic        force_role_bit,
  input wire logic [15:0] partner_upper_live,
  input wire logic        adv_long_reach,
  input wire logic        tx_nonce_role,
  input wire logic        tx_role_forced,
  input wire logic        adv_hi_able,
  input wire logic        adv_hi_req,
  input wire logic        tx_level_high
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // Reset state, judged at the first edge after release
  reset_values_a: assert property ($rose(rstn) |-> adv_long_reach &&
    !tx_level_high && !tx_role_forced && mdio_oe_n)
    else $error("reset state wrong");
  reset_straps_a: assert property ($rose(rstn) |->
    tx_nonce_role == $past(strap_role_master) &&
    adv_hi_able == $past(strap_hi_able) && adv_hi_req == $past(strap_hi_req))
    else $error("strap values not loaded");

  // Level resolution and the force bit, one cycle behind their causes
  low_unable_a: assert property ($past(rstn) &&
    !$past(adv_hi_able && partner_upper_live[13]) |-> !tx_level_high)
    else $error("high level without both able");
  high_request_a: assert property ($past(rstn) && $past(adv_hi_able &&
    partner_upper_live[13] && (adv_hi_req || partner_upper_live[12]))
    |-> tx_level_high) else $error("high level not chosen");
  low_no_request_a: assert property ($past(rstn) && $past(adv_hi_able &&
    partner_upper_live[13] && !adv_hi_req && !partner_upper_live[12])
    |-> !tx_level_high) else $error("high level without request");
  force_follow_a: assert property ($past(rstn) |->
    tx_role_forced == $past(force_role_bit)) else $error("force bit lost");

  // Writes land only just after an mdc rise, never while the PHY talks; the turnaround bit is driven low
  reach_write_a: assert property ($past(rstn) && $changed(adv_long_reach)
    |-> $past(mdc) && mdio_oe_n) else $error("reach bit moved oddly");
  role_write_a: assert property ($past(rstn) && $changed(tx_nonce_role)
    |-> $past(mdc) && mdio_oe_n) else $error("role bit moved oddly");
  turn_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround not driven low");

  cover property (tx_level_high);
  cover property ($fell(mdio_oe_n));
  cover property ($rose(tx_role_forced));
endmodule // ability_regs_props

bind base_t1_autoneg_ability_regs ability_regs_props u_props (
  .sys_clk(sys_clk), .rstn(rstn), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n), .strap_role_master(strap_role_master),
  .strap_hi_able(strap_hi_able), .strap_hi_req(strap_hi_req),
  .force_role_bit(force_role_bit), .partner_upper_live(partner_upper_live),
  .adv_long_reach(adv_long_reach), .tx_nonce_role(tx_nonce_role),
  .tx_role_forced(tx_role_forced), .adv_hi_able(adv_hi_able),
  .adv_hi_req(adv_hi_req), .tx_level_high(tx_level_high));

`default_nettype wire

// ===== verif/link_partner_model.sv
// Behavioural link partner that supplies its received base page
`timescale 1ns/1ns
`default_nettype none

module link_partner_model (
  input  wire logic [47:0] page_cfg,
  input  wire logic        local_hi_able,
  input  wire logic        local_hi_req,
  output logic      [15:0] low_word,
  output logic      [15:0] middle_word,
  output logic      [15:0] upper_word,
  output logic             level_high
);
  ////////////////////////////////////////////////////////////////////////////
  // Reserved bits pass through as sent, so the PHY must mask them itself
  assign low_word    = {page_cfg[15:5], 5'h01};
  assign middle_word = page_cfg[31:16];
  assign upper_word  = page_cfg[47:32];
  // The partner settles the level by the same table as the local end
  assign level_high  = local_hi_able & upper_word[13] &
                       (local_hi_req | upper_word[12]);
endmodule // link_partner_model

`default_nettype wire

// ===== verif/base_t1_autoneg_ability_regs_test.sv
// Self-checking bench for the ability register slice
`timescale 1ns/1ns
`default_nettype none

module base_t1_autoneg_ability_regs_test;
  localparam logic [4:0] PORT = 5'h05;
  logic        sys_clk, rstn, mdc, host_drv, strap_m, strap_a, strap_r;
  logic        force_r, mdio_out, mdio_oe_n, long_r, role, forced;
  logic        hi_a, hi_r, lvl, p_lvl;
  logic [47:0] page;
  logic [15:0] lp_low, lp_mid, lp_up, rd_val;
  int          error_cnt, checked;
  // Open-drain style wire: host side idles high when released
  wire logic   mdio_wire = mdio_oe_n ? host_drv : mdio_out;

  base_t1_autoneg_ability_regs u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .phy_addr(PORT), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .strap_role_master(strap_m),
    .strap_hi_able(strap_a), .strap_hi_req(strap_r),
    .force_role_bit(force_r), .partner_low_live(lp_low),
    .partner_middle_live(lp_mid), .partner_upper_live(lp_up),
    .adv_long_reach(long_r), .tx_nonce_role(role), .tx_role_forced(forced),
    .adv_hi_able(hi_a), .adv_hi_req(hi_r), .tx_level_high(lvl));
  link_partner_model u_partner (.page_cfg(page), .local_hi_able(hi_a),
    .local_hi_req(hi_r), .low_word(lp_low), .middle_word(lp_mid),
    .upper_word(lp_up), .level_high(p_lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [18:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One mdc period of five clocks; sample what the last rise produced
  task automatic bit_io(input logic b, output logic o, oe);
    @(posedge sys_clk);
    o = mdio_out;
    oe = mdio_oe_n;
    mdc <= 1'b0;
    host_drv <= b;
    repeat (2) @(posedge sys_clk);
    mdc <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  // Whole frame; the trailing idle bit shows the PHY letting go
  task automatic frame(input logic [4:0] prt, input logic [1:0] op,
                       input logic [15:0] val, input logic drv);
    logic [45:0] head;
    logic [17:0] tail;
    logic [18:0] oe_seq;
    logic        o, oe, ta;
    head = {32'hFFFF_FFFF, 2'h0, op, prt, base_t1_an_pkg::AN_DEVAD};
    tail = op[1] ? 18'h3FFFF : {2'h2, val};
    for (int i = 45; i >= 0; i--) bit_io(head[i], o, oe);
    for (int i = 0; i < 19; i++) begin
      bit_io(i < 18 ? tail[17 - i] : 1'b1, o, oe);
      oe_seq[i] = oe;
      if (i == 1) ta = o;
      if (i > 1 && i < 18) rd_val[17 - i] = o;
    end
    check("drive window", oe_seq, drv ? 19'h40001 : 19'h7FFFF);
    if (drv) check("turnaround", ta, 1'b0);
  endtask

  task automatic wr(input logic [15:0] a, d);
    frame(PORT, base_t1_an_pkg::OP_ADDRESS, a, 1'b0);
    frame(PORT, base_t1_an_pkg::OP_WRITE, d, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a);
    frame(PORT, base_t1_an_pkg::OP_ADDRESS, a, 1'b0);
    frame(PORT, base_t1_an_pkg::OP_READ, 16'hFFFF, 1'b1);
  endtask

  task automatic do_reset(input logic m, a, r);
    @(posedge sys_clk);
    rstn <= 1'b0;
    strap_m <= m;
    strap_a <= a;
    strap_r <= r;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Two resets with opposite straps
  task automatic t_reset;
    do_reset(1'b1, 1'b1, 1'b0);
    rd(16'h0203); check("middle", rd_val, 16'h4010);
    rd(16'h0204); check("upper", rd_val, 16'h2000);
    do_reset(1'b0, 1'b0, 1'b1);
    rd(16'h0203); check("middle", rd_val, 16'h4000);
    rd(16'h0204); check("upper", rd_val, 16'h1000);
    check("reach out", long_r, 1'b1);
    check("hi out", {hi_a, hi_r}, 2'h1);
  endtask

  // All ones then all zeros to the middle word, all ones to the upper: only the writable bits may move
  task automatic t_writes;
    wr(16'h0203, 16'hFFFF);
    rd(16'h0203); check("middle", rd_val, 16'h4010);
    check("nonce role", role, 1'b1);
    wr(16'h0203, 16'h0000);
    rd(16'h0203); check("middle", rd_val, 16'h0000);
    check("reach out", long_r, 1'b0);
    check("nonce role", role, 1'b0);
    wr(16'h0204, 16'hFFFF);
    rd(16'h0204); check("upper", rd_val, 16'h3000);
    check("hi out", {hi_a, hi_r}, 2'h3);
  endtask

  // Every pairing of local and partner ability and request
  task automatic t_level;
    logic exp;
    for (int l = 0; l < 4; l++) begin
      wr(16'h0204, {2'h0, l[1:0], 12'h000});
      for (int p = 0; p < 4; p++) begin
        page[45:44] <= p[1:0];
        repeat (3) @(posedge sys_clk);
        exp = l[1] & p[1] & (l[0] | p[0]);
        check("level", lvl, exp);
        check("both ends", lvl, p_lvl);
      end
    end
  endtask

  // Partner low word fields and the copy taken on its read
  task automatic t_partner;
    @(posedge sys_clk) page <= 48'h3000_5A5A_A400;
    rd(16'h0205); check("partner low", rd_val, 16'hA401);
    @(posedge sys_clk) page <= 48'h0000_1111_FFFF;
    rd(16'h0206); check("held middle", rd_val, 16'h5A5A);
    rd(16'h0207); check("held upper", rd_val, 16'h3000);
    rd(16'h0205); check("partner low", rd_val, 16'hFC01);
    rd(16'h0206); check("held middle", rd_val, 16'h1111);
    // Read with increment: returns 0x0206, then 0x0207 follows
    frame(PORT, base_t1_an_pkg::OP_READ_INC, 16'hFFFF, 1'b1);
    check("inc read", rd_val, 16'h1111);
    frame(PORT, base_t1_an_pkg::OP_READ, 16'hFFFF, 1'b1);
    check("after inc", rd_val, 16'h0000);
  endtask

  // Refused writes, a foreign port and an unmapped address
  task automatic t_refused;
    wr(16'h0205, 16'h0000);
    rd(16'h0205); check("partner low", rd_val, 16'hFC01);
    frame(5'h1A, base_t1_an_pkg::OP_ADDRESS, 16'h0204, 1'b0);
    frame(5'h1A, base_t1_an_pkg::OP_WRITE, 16'h0000, 1'b0);
    frame(5'h1A, base_t1_an_pkg::OP_READ, 16'hFFFF, 1'b0);
    rd(16'h0204); check("upper", rd_val, 16'h3000);
    rd(16'h0202); check("unmapped", rd_val, 16'h0000);
  endtask

  task automatic t_force;
    @(posedge sys_clk) force_r <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("role forced", forced, 1'b1);
    force_r <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("role forced", forced, 1'b0);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Whole run needs under 20000 clocks
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    rstn = 1'b0;
    mdc = 1'b0;
    host_drv = 1'b1;
    {strap_m, strap_a, strap_r, force_r} = 4'h0;
    page = 48'h0;
    t_reset;
    t_writes;
    t_level;
    t_partner;
    t_refused;
    t_force;
    tally_and_finish;
  end
endmodule // base_t1_autoneg_ability_regs_test

`default_nettype wire
